// [common/pph_pkg.sv]
// pph_pkg: constants and types of the parallel i/o handshake block
// assumes a 250 MHz pclk and an apb master with 32-bit data
package pph_pkg;
   // ------------------------------------------------
   // apb register map
   // ------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] ZONE_LO_OFF = 8'h00;
   localparam logic [7:0] ZONE_HI_OFF = 8'h04;
   localparam logic [7:0] POS_VALID_OFF = 8'h08;
   localparam logic [7:0] PUSH_MASK_OFF = 8'h0c;
   localparam logic [7:0] STATUS_OFF = 8'h10;
   localparam logic [7:0] ALARM_OFF = 8'h14;
   localparam logic [15:0] ZONE_LO_RST = 16'h0000;
   localparam logic [15:0] ZONE_HI_RST = 16'hffff;
   localparam logic [15:0] POS_VALID_RST = 16'h0000;
   localparam logic [15:0] PUSH_MASK_RST = 16'h0000;
   // ------------------------------------------------
   // host pin vector
   // ------------------------------------------------
   localparam int PIN_W = 9;
   localparam int PIN_PAUSE = 0;
   localparam int PIN_SERVO = 1;
   localparam int PIN_RST = 2;
   localparam int PIN_START = 3;
   localparam int PIN_EMG = 4;
   localparam int PIN_CMD = 5;
   localparam int CMD_W = 4;
   // pause and emergency lines idle on
   localparam logic [8:0] PIN_IDLE = 9'h011;
   // ------------------------------------------------
   // alarm codes
   // ------------------------------------------------
   localparam logic [11:0] ALM_NONE = 12'h000;
   localparam logic [11:0] ALM_OVERCUR = 12'h0c8;
   localparam logic [11:0] ALM_NODATA = 12'h0b1;
   localparam logic [11:0] ALM_BATT = 12'h0e5;
   // generic fault code, value arbitrary
   localparam logic [11:0] ALM_FAULT = 12'h0a1;
   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam longint unsigned CLK_HZ = 250_000_000;
   localparam longint unsigned SEC_PER_HOUR = 3600;
   localparam longint unsigned BATT_HOURS = 220;
   localparam logic [63:0] BATT_CYCLES =
      64'(BATT_HOURS * SEC_PER_HOUR * CLK_HZ);
   localparam logic [63:0] CNT_ONE = 64'h0000_0000_0000_0001;
   localparam logic [63:0] CNT_ZERO = 64'h0000_0000_0000_0000;
   typedef enum logic [1:0] {
      pph_boot,
      pph_ready,
      pph_home,
      pph_move
   } pph_state_t;
endpackage : pph_pkg

// [design/pph_io_handshake.sv]
// pph_io_handshake: host parallel port handshake of a positioner
// assumes host pins are asynchronous, motion engine on pclk
`timescale 1ns/1ps
// Behaviour
// - alarm, stop, pause lines idle on; battery line idles on in absolute variant only
// - alarm output off while any alarm
// - reset rise clears no-data and fault alarms only
// - reset during pause discards remaining travel
// - zone on while position inside zone
// - home done held after first homing
// - homing precedes move while home not done
// - absolute variant restores home done at boot if reference valid and no battery error
// - position complete drops on start, rises done
// - codes cleared with position complete
// - codes off during stop or teaching
// - on ready show last code if in band
// - push mode keeps codes off on return
// - battery alarm off when battery low
// - long battery alarm sets battery warning status bit
// - incremental variant holds battery alarm off
// - moving on while actuator moves
// - stop status off while stop active
// - servo follows servo on input
// - four bit binary target, start begins move
// - start on empty position raises no-data alarm
// - boot battery error blocks until absolute reset
module pph_io_handshake #(
   parameter logic [63:0] BATT_ERR_CYCLES = pph_pkg::BATT_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pph_pkg::ADDR_W-1:0] paddr,
   input wire logic [pph_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [pph_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // host input pins
   input wire logic pause_n_in,
   input wire logic servo_on_in,
   input wire logic reset_in,
   input wire logic start_in,
   input wire logic [pph_pkg::CMD_W-1:0] cmd_pos_in,
   input wire logic emg_stop_n_in,
   // host output pins
   output logic alarm_n,
   output logic zone,
   output logic home_done,
   output logic pos_complete,
   output logic [pph_pkg::CMD_W-1:0] done_pos,
   output logic batt_alarm_n,
   output logic moving,
   output logic emg_stop_n,
   // motion engine status
   input wire logic homing_done,
   input wire logic move_done,
   input wire logic motion_active,
   input wire logic in_band,
   input wire logic [15:0] act_pos,
   input wire logic overcurrent,
   input wire logic fault,
   input wire logic batt_low,
   input wire logic teach_mode,
   input wire logic abs_variant,
   input wire logic abs_ref_valid,
   input wire logic batt_err_boot,
   input wire logic abs_reset_done,
   // motion engine commands
   output logic move_req,
   output logic home_req,
   output logic [pph_pkg::CMD_W-1:0] move_target,
   output logic hold_motion,
   output logic cancel_travel,
   output logic servo_en
);
   import pph_pkg::*;

   // ------------------------------------------------
   // state
   // ------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] s1, s2, s3, f, fp;
      pph_state_t st;
      logic abs_var, home_done, pos_cplt;
      logic [CMD_W-1:0] code, last_pos, target;
      logic last_push, moving, move_req, home_req;
      logic hold, cancel, servo_en, zone;
      logic alarm_n, emg_n, batt_n, blk_prev;
      logic oc_alm, miss_alm, fault_alm;
      logic batt_err, batt_warn;
      logic [63:0] batt_cnt;
      logic [15:0] zone_lo, zone_hi;
      logic [15:0] pos_valid, push_mask;
      logic [11:0] alm_code;
      logic pready, pslverr;
      logic [DATA_W-1:0] prdata;
   } pph_reg_t;

   localparam pph_reg_t Q_RST = '{
      s1: PIN_IDLE,
      s2: PIN_IDLE,
      s3: PIN_IDLE,
      f: PIN_IDLE,
      fp: PIN_IDLE,
      st: pph_boot,
      zone_lo: ZONE_LO_RST,
      zone_hi: ZONE_HI_RST,
      pos_valid: POS_VALID_RST,
      push_mask: PUSH_MASK_RST,
      default: '0
   };

   pph_reg_t q;
   pph_reg_t n;

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   function automatic logic filt(input logic a, input logic b,
                                 input logic old);
      filt = (a == b) ? a : old;
   endfunction : filt

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == ZONE_LO_OFF) || (a == ZONE_HI_OFF) ||
                  (a == POS_VALID_OFF) || (a == PUSH_MASK_OFF) ||
                  (a == STATUS_OFF) || (a == ALARM_OFF);
   endfunction : is_mapped

   function automatic logic [15:0] wmerge(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      wmerge = old;
      if (s[0]) begin
         wmerge[7:0] = d[7:0];
      end
      if (s[1]) begin
         wmerge[15:8] = d[15:8];
      end
   endfunction : wmerge

   logic [PIN_W-1:0] pins;
   logic start_rise;
   logic rst_rise;
   logic emg;
   logic blk;
   logic alm;
   logic op_ok;
   logic ret;
   logic acc;
   logic [CMD_W-1:0] sel;
   logic [CMD_W-1:0] ret_code;
   logic [15:0] stat;

   assign pins = {cmd_pos_in, emg_stop_n_in, start_in, reset_in,
                  servo_on_in, pause_n_in};
   assign start_rise = q.f[PIN_START] && !q.fp[PIN_START];
   assign rst_rise = q.f[PIN_RST] && !q.fp[PIN_RST];
   assign emg = !q.f[PIN_EMG];
   assign blk = emg || teach_mode;
   assign alm = q.oc_alm || q.batt_err || q.fault_alm || q.miss_alm;
   assign op_ok = q.f[PIN_SERVO] && !alm && !blk;
   assign ret = q.blk_prev && !blk && (q.st == pph_ready);
   assign acc = psel && penable;
   assign sel = q.f[PIN_CMD +: CMD_W];
   assign ret_code = (in_band && !q.last_push) ? q.last_pos : 4'h0;
   assign stat = {q.last_pos, 3'b000, q.batt_warn, q.batt_err,
                  q.oc_alm, q.fault_alm, q.miss_alm, q.moving,
                  q.pos_cplt, q.home_done, alm};

   // ------------------------------------------------
   // next state
   // ------------------------------------------------
   always_comb begin
      n = q;
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      for (int i = 0; i < PIN_W; i++) begin
         n.f[i] = filt(q.s2[i], q.s3[i], q.f[i]);
      end
      n.fp = q.f;
      n.move_req = 1'b0;
      n.home_req = 1'b0;
      n.cancel = 1'b0;
      n.blk_prev = blk;

      if (rst_rise) begin
         n.miss_alm = 1'b0;
         n.fault_alm = 1'b0;
      end
      if (fault) begin
         n.fault_alm = 1'b1;
      end
      if (overcurrent) begin
         n.oc_alm = 1'b1;
      end
      if (abs_reset_done && q.abs_var) begin
         n.batt_err = 1'b0;
         n.home_done = 1'b1;
      end

      case (q.st)
         pph_boot: begin
            n.abs_var = abs_variant;
            n.home_done = abs_variant && abs_ref_valid &&
                          !batt_err_boot;
            n.batt_err = abs_variant && batt_err_boot;
            n.pos_cplt = 1'b1;
            n.code = 4'h0;
            n.st = pph_ready;
         end
         pph_ready: begin
            if (rst_rise && !q.pos_cplt && !blk) begin
               n.pos_cplt = 1'b1;
               n.code = 4'h0;
            end
            if (start_rise && op_ok) begin
               if (!q.pos_valid[sel]) begin
                  n.miss_alm = 1'b1;
               end else begin
                  n.target = sel;
                  n.pos_cplt = 1'b0;
                  if (q.home_done) begin
                     n.move_req = 1'b1;
                     n.st = pph_move;
                  end else begin
                     n.home_req = 1'b1;
                     n.st = pph_home;
                  end
               end
            end
         end
         pph_home: begin
            if (blk || alm || !q.f[PIN_SERVO]) begin
               n.st = pph_ready;
            end else if (homing_done) begin
               n.home_done = 1'b1;
               n.move_req = 1'b1;
               n.st = pph_move;
            end
         end
         pph_move: begin
            if (blk || alm || !q.f[PIN_SERVO]) begin
               n.st = pph_ready;
            end else if (!q.f[PIN_PAUSE] && rst_rise) begin
               n.cancel = 1'b1;
               n.pos_cplt = 1'b1;
               n.code = 4'h0;
               n.st = pph_ready;
            end else if (move_done) begin
               n.pos_cplt = 1'b1;
               n.code = q.target;
               n.last_pos = q.target;
               n.last_push = q.push_mask[q.target];
               n.st = pph_ready;
            end
         end
         default: begin
            n.st = pph_ready;
         end
      endcase

      // last code if still in band
      if (ret) begin
         n.pos_cplt = 1'b1;
         n.code = ret_code;
      end
      if (blk) begin
         n.code = 4'h0;
      end
      if (!n.pos_cplt) begin
         n.code = 4'h0;
      end

      // alarm line off on any alarm
      n.alarm_n = !(n.oc_alm || n.batt_err || n.fault_alm ||
                    n.miss_alm);
      if (n.oc_alm) begin
         n.alm_code = ALM_OVERCUR;
      end else if (n.batt_err) begin
         n.alm_code = ALM_BATT;
      end else if (n.fault_alm) begin
         n.alm_code = ALM_FAULT;
      end else if (n.miss_alm) begin
         n.alm_code = ALM_NODATA;
      end else begin
         n.alm_code = ALM_NONE;
      end

      n.batt_n = q.abs_var && !batt_low;
      if (q.abs_var && batt_low) begin
         if (q.batt_cnt >= BATT_ERR_CYCLES) begin
            n.batt_warn = 1'b1;
         end else begin
            n.batt_cnt = q.batt_cnt + CNT_ONE;
         end
      end else begin
         n.batt_cnt = CNT_ZERO;
         n.batt_warn = 1'b0;
      end

      n.zone = (act_pos >= q.zone_lo) && (act_pos <= q.zone_hi);
      n.moving = motion_active;
      n.emg_n = !emg;
      n.hold = !q.f[PIN_PAUSE];
      n.servo_en = q.f[PIN_SERVO];

      // apb slave, one wait state
      n.pready = acc && !q.pready;
      n.pslverr = 1'b0;
      if (acc && !q.pready) begin
         n.pslverr = !is_mapped(paddr);
         case (paddr)
            ZONE_LO_OFF: begin
               n.prdata = {16'h0000, q.zone_lo};
            end
            ZONE_HI_OFF: begin
               n.prdata = {16'h0000, q.zone_hi};
            end
            POS_VALID_OFF: begin
               n.prdata = {16'h0000, q.pos_valid};
            end
            PUSH_MASK_OFF: begin
               n.prdata = {16'h0000, q.push_mask};
            end
            STATUS_OFF: begin
               n.prdata = {16'h0000, stat};
            end
            ALARM_OFF: begin
               n.prdata = {20'h0_0000, q.alm_code};
            end
            default: begin
               n.prdata = 32'h0000_0000;
            end
         endcase
      end
      if (acc && q.pready && pwrite && is_mapped(paddr)) begin
         case (paddr)
            ZONE_LO_OFF: begin
               n.zone_lo = wmerge(q.zone_lo, pwdata, pstrb);
            end
            ZONE_HI_OFF: begin
               n.zone_hi = wmerge(q.zone_hi, pwdata, pstrb);
            end
            POS_VALID_OFF: begin
               n.pos_valid = wmerge(q.pos_valid, pwdata, pstrb);
            end
            PUSH_MASK_OFF: begin
               n.push_mask = wmerge(q.push_mask, pwdata, pstrb);
            end
            default: begin
               n.prdata = q.prdata;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= Q_RST;
      end else begin
         q <= n;
      end
   end

   // ------------------------------------------------
   // outputs
   // ------------------------------------------------
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign alarm_n = q.alarm_n;
   assign zone = q.zone;
   assign home_done = q.home_done;
   assign pos_complete = q.pos_cplt;
   assign done_pos = q.code;
   assign batt_alarm_n = q.batt_n;
   assign moving = q.moving;
   assign emg_stop_n = q.emg_n;
   assign move_req = q.move_req;
   assign home_req = q.home_req;
   assign move_target = q.target;
   assign hold_motion = q.hold;
   assign cancel_travel = q.cancel;
   assign servo_en = q.servo_en;

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence start_ok_s;
      q.st == pph_ready && start_rise && op_ok && q.pos_valid[sel];
   endsequence
   sequence paused_rst_s;
      q.st == pph_move && !q.f[PIN_PAUSE] && rst_rise && op_ok;
   endsequence

   alarm_line_a:
      assert property (q.oc_alm |=> !alarm_n)
      else $error("alarm line on during overcurrent");
   alarm_clear_a:
      assert property (rst_rise && !fault && !start_rise
                       |=> !q.miss_alm && !q.fault_alm)
      else $error("reset edge left alarm set");
   oc_sticky_a:
      assert property (q.oc_alm |=> q.oc_alm)
      else $error("overcurrent alarm cleared");
   cancel_pause_a:
      assert property (paused_rst_s |=> cancel_travel && pos_complete
                       ##1 !cancel_travel)
      else $error("paused travel not cancelled");
   zone_win_a:
      assert property (act_pos >= q.zone_lo && act_pos <= q.zone_hi
                       |=> zone)
      else $error("zone off inside window");
   home_keep_a:
      assert property (home_done && q.st != pph_boot |=> home_done)
      else $error("home done dropped");
   home_first_a:
      assert property (start_ok_s ##0 !home_done
                       |=> home_req && !move_req)
      else $error("move without homing");
   start_take_a:
      assert property (start_ok_s |=> !pos_complete &&
                       move_target == $past(sel))
      else $error("start not taken with select");
   code_clear_a:
      assert property (!pos_complete |-> done_pos == 4'h0)
      else $error("code shown without complete");
   code_blk_a:
      assert property (blk |=> done_pos == 4'h0)
      else $error("code shown while blocked");
   ret_code_a:
      assert property (ret |=> pos_complete &&
                       done_pos == $past(ret_code))
      else $error("wrong code on return to ready");
   batt_off_a:
      assert property (!q.abs_var && q.st != pph_boot |=> !batt_alarm_n)
      else $error("battery line on in incremental variant");
   nodata_a:
      assert property (q.st == pph_ready && start_rise && op_ok &&
                       !q.pos_valid[sel] |=> q.miss_alm && !move_req)
      else $error("missing data not flagged");
   sync_a:
      assert property (((q.f ^ q.fp) & ($past(q.s2) ^ $past(q.s3))) == '0)
      else $error("input taken before agreement");
endmodule : pph_io_handshake

// [test/pph_host_model.sv]
// pph_host_model: host controller driving the parallel input pins
// assumes one-cycle go_start/go_reset requests from the bench on pclk
`timescale 1ns/1ps
module pph_host_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench requests
   input wire logic go_start,
   input wire logic go_reset,
   input wire logic [3:0] sel,
   input wire logic want_pause,
   input wire logic want_servo,
   input wire logic want_emg,
   // host pins
   output logic pause_n_in,
   output logic servo_on_in,
   output logic reset_in,
   output logic start_in,
   output logic [3:0] cmd_pos_in,
   output logic emg_stop_n_in
);
   int st_cnt;
   int rs_cnt;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pause_n_in <= 1'h1;
         emg_stop_n_in <= 1'h1;
         servo_on_in <= 1'h0;
         reset_in <= 1'h0;
         start_in <= 1'h0;
         cmd_pos_in <= 4'h0;
         st_cnt <= 0;
         rs_cnt <= 0;
      end else begin
         pause_n_in <= !want_pause;
         servo_on_in <= want_servo;
         emg_stop_n_in <= !want_emg;
         if (go_start) begin
            cmd_pos_in <= sel;
            st_cnt <= 8;
         end else if (st_cnt > 0) begin
            st_cnt <= st_cnt - 1;
         end
         // select lines released late show garbage
         if (st_cnt == 1) begin
            cmd_pos_in <= ~cmd_pos_in;
         end
         start_in <= (st_cnt > 0);
         if (go_reset) begin
            rs_cnt <= 8;
         end else if (rs_cnt > 0) begin
            rs_cnt <= rs_cnt - 1;
         end
         reset_in <= (rs_cnt > 0);
      end
   end
endmodule : pph_host_model

// [test/pph_io_handshake_bench.sv]
// pph_io_handshake_bench: self-checking bench of the handshake block
// assumes the host model on the pins and a bench-driven motion engine
`timescale 1ns/1ps
module pph_io_handshake_bench;
   import pph_pkg::*;
   logic pclk = 1'h0, presetn = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0] pstrb = 4'h0, sel = 4'h0, cmd_pos_in, done_pos, move_target;
   logic go_start = 1'h0, go_reset = 1'h0, want_pause = 1'h0;
   logic want_servo = 1'h1, want_emg = 1'h0;
   logic pause_n_in, servo_on_in, reset_in, start_in, emg_stop_n_in;
   logic alarm_n, zone, home_done, pos_complete, batt_alarm_n, moving;
   logic emg_stop_n, move_req, home_req, hold_motion, cancel_travel;
   logic servo_en, homing_done = 1'h0, move_done = 1'h0;
   logic motion_active = 1'h0, in_band = 1'h1, overcurrent = 1'h0;
   logic fault = 1'h0, batt_low = 1'h0, teach_mode = 1'h0;
   logic abs_variant = 1'h0, abs_ref_valid = 1'h0, batt_err_boot = 1'h0;
   logic abs_reset_done = 1'h0;
   logic [15:0] act_pos = 16'h0000;
   logic [15:0] zp [4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
   int num_errors = 0, tests_run = 0, cyc = 0, last = 0;
   int seed = 32'ha0fe_4c52;
   int q[$];
   pph_io_handshake #(.BATT_ERR_CYCLES(64'h0000_0000_0000_0014))
   pph_io_handshake_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pause_n_in,
      .servo_on_in, .reset_in, .start_in, .cmd_pos_in, .emg_stop_n_in,
      .alarm_n, .zone, .home_done, .pos_complete, .done_pos,
      .batt_alarm_n, .moving, .emg_stop_n, .homing_done, .move_done,
      .motion_active, .in_band, .act_pos, .overcurrent, .fault,
      .batt_low, .teach_mode, .abs_variant, .abs_ref_valid,
      .batt_err_boot, .abs_reset_done, .move_req, .home_req,
      .move_target, .hold_motion, .cancel_travel, .servo_en);
   pph_host_model pph_host_model_inst (.pclk, .presetn, .go_start,
      .go_reset, .sel, .want_pause, .want_servo, .want_emg, .pause_n_in,
      .servo_on_in, .reset_in, .start_in, .cmd_pos_in, .emg_stop_n_in);
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hf;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'h1, a, d, e);
   endtask : wr
   task automatic chk_reg(input string nm, input logic [7:0] a,
                          input logic [31:0] x, input logic xe);
      logic e;
      apb(1'h0, a, 32'h0000_0000, e);
      chk(nm, x, rd);
      chk(nm, xe, e);
   endtask : chk_reg
   function automatic logic hit(input int w);
      case (w)
         0: return move_req | home_req;
         1: return move_req;
         2: return cancel_travel;
         3: return !emg_stop_n;
         4: return emg_stop_n;
         default: return !servo_en;
      endcase
   endfunction : hit
   task automatic wait_on(input int w);
      int n;
      n = 0;
      #1;
      while (hit(w) !== 1'h1 && n < 40) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk("handshake", 1, hit(w));
   endtask : wait_on
   task automatic settle(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask : settle
   task automatic pulse_reset;
      @(posedge pclk);
      go_reset <= 1'h1;
      @(posedge pclk);
      go_reset <= 1'h0;
   endtask : pulse_reset
   task automatic poke(input int p);
      repeat (12) @(posedge pclk);
      sel <= p[3:0];
      go_start <= 1'h1;
      @(posedge pclk);
      go_start <= 1'h0;
   endtask : poke
   task automatic start_mv(input int p);
      poke(p);
      q.push_back(p);
      wait_on(0);
      if (home_req === 1'h1) begin
         chk("home_done early", 0, home_done);
         @(posedge pclk);
         homing_done <= 1'h1;
         @(posedge pclk);
         homing_done <= 1'h0;
         wait_on(1);
         chk("home_done", 1, home_done);
      end
      chk("pos_complete drop", 0, pos_complete);
      chk("done_pos clear", 0, done_pos);
      chk("move_target", p, move_target);
      @(posedge pclk);
      motion_active <= 1'h1;
      settle(2);
      chk("moving", 1, moving);
   endtask : start_mv
   task automatic end_mv;
      @(posedge pclk);
      motion_active <= 1'h0;
      move_done <= 1'h1;
      @(posedge pclk);
      move_done <= 1'h0;
      #1;
      last = q.pop_front();
      chk("target held", last, move_target);
      chk("pos_complete rise", 1, pos_complete);
      chk("done_pos", last, done_pos);
   endtask : end_mv
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      settle(8);
      chk("alarm_n boot", 1, alarm_n);
      chk("emg_stop_n boot", 1, emg_stop_n);
      chk("pos_complete boot", 1, pos_complete);
      chk("servo_en", 1, servo_en);
      chk_reg("zone_hi", ZONE_HI_OFF, 32'h0000_ffff, 1'h0);
      chk_reg("pos_valid", POS_VALID_OFF, 32'h0000_0000, 1'h0);
      chk_reg("unmapped", 8'h18, 32'h0000_0000, 1'h1);
      $display("test boot done");
      wr(ZONE_LO_OFF, 32'h0000_0100);
      wr(ZONE_HI_OFF, 32'h0000_0200);
      foreach (zp[i]) begin
         @(posedge pclk);
         act_pos <= zp[i];
         settle(3);
         chk("zone", zp[i] >= 16'h0100 && zp[i] <= 16'h0200, zone);
      end
      $display("test zone done");
      wr(POS_VALID_OFF, 32'h0000_7fff);
      for (int i = 0; i < 7; i++) begin
         start_mv($unsigned($random(seed)) % 15);
         end_mv();
      end
      @(posedge pclk);
      batt_low <= 1'h1;
      settle(3);
      chk("batt_alarm_n", 0, batt_alarm_n);
      $display("test moves done");
      for (int k = 0; k < 3; k++) begin
         wr(PUSH_MASK_OFF, k == 1 ? 32'h0000_0020 : 32'h0000_0000);
         start_mv(5);
         end_mv();
         @(posedge pclk);
         want_emg <= 1'h1;
         in_band <= (k != 2);
         wait_on(3);
         settle(2);
         chk("done_pos stop", 0, done_pos);
         chk("home_done kept", 1, home_done);
         @(posedge pclk);
         want_emg <= 1'h0;
         wait_on(4);
         settle(2);
         chk("done_pos back", k ? 0 : 5, done_pos);
      end
      $display("test stop done");
      start_mv(2);
      @(posedge pclk);
      want_pause <= 1'h1;
      settle(6);
      chk("hold_motion", 1, hold_motion);
      pulse_reset();
      wait_on(2);
      chk("pos_complete cancel", 1, pos_complete);
      chk("done_pos cancel", 0, done_pos);
      q.delete();
      @(posedge pclk);
      motion_active <= 1'h0;
      want_pause <= 1'h0;
      $display("test pause done");
      poke(15);
      settle(10);
      chk("alarm_n nodata", 0, alarm_n);
      chk("no move", 1, pos_complete);
      chk_reg("code", ALARM_OFF, 32'(ALM_NODATA), 1'h0);
      pulse_reset();
      settle(14);
      chk("alarm_n cleared", 1, alarm_n);
      @(posedge pclk);
      fault <= 1'h1;
      settle(3);
      chk("alarm_n fault", 0, alarm_n);
      pulse_reset();
      settle(14);
      chk("alarm_n persists", 0, alarm_n);
      @(posedge pclk);
      fault <= 1'h0;
      pulse_reset();
      settle(14);
      chk("alarm_n fault gone", 1, alarm_n);
      @(posedge pclk);
      overcurrent <= 1'h1;
      @(posedge pclk);
      overcurrent <= 1'h0;
      pulse_reset();
      settle(14);
      chk("alarm_n overcurrent", 0, alarm_n);
      chk_reg("code", ALARM_OFF, 32'(ALM_OVERCUR), 1'h0);
      @(posedge pclk);
      want_servo <= 1'h0;
      wait_on(5);
      $display("test alarms done");
      @(posedge pclk);
      abs_variant <= 1'h1;
      abs_ref_valid <= 1'h1;
      batt_err_boot <= 1'h1;
      presetn <= 1'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      settle(3);
      chk("alarm_n batt err", 0, alarm_n);
      chk("home_done batt err", 0, home_done);
      chk_reg("code", ALARM_OFF, 32'(ALM_BATT), 1'h0);
      @(posedge pclk);
      abs_reset_done <= 1'h1;
      batt_low <= 1'h0;
      @(posedge pclk);
      abs_reset_done <= 1'h0;
      settle(2);
      chk("alarm_n abs reset", 1, alarm_n);
      chk("home_done abs reset", 1, home_done);
      chk("batt_alarm_n ok", 1, batt_alarm_n);
      @(posedge pclk);
      batt_low <= 1'h1;
      settle(30);
      chk("batt_alarm_n low", 0, batt_alarm_n);
      chk_reg("status", STATUS_OFF, 32'h0000_0106, 1'h0);
      $display("test absolute done");
      summarize();
   end
endmodule : pph_io_handshake_bench
